// *** common/eif_pkg.sv ***
// shared constants and carrier types of the external interrupt front end
package eif_pkg;
	localparam logic [31:0] EIF_FALL0_ADDR = 32'hFFFFF300;
	localparam logic [31:0] EIF_RISE0_ADDR = 32'hFFFFF304;
	localparam logic [31:0] EIF_FALL3_ADDR = 32'hFFFFF308;
	localparam logic [31:0] EIF_RISE3_ADDR = 32'hFFFFF30C;
	localparam logic [31:0] EIF_FALL9_ADDR = 32'hFFFFF310;
	localparam logic [31:0] EIF_RISE9_ADDR = 32'hFFFFF314;
	localparam logic [31:0] EIF_NFC_ADDR = 32'hFFFFF318;
	localparam logic [31:0] EIF_STAT_ADDR = 32'hFFFFF320;
	localparam logic [7:0] EIF_REG_RST = 8'h00;
	localparam int EIF_NMI_BIT = 2;
	localparam int EIF_G0_LO = 3;
	localparam int EIF_G3_BIT = 1;
	localparam int EIF_G9_LO = 5;
	localparam int EIF_NF_EN_BIT = 7;
	localparam int EIF_NF_CNT_BIT = 6;
	localparam logic [2:0] EIF_SEL_SUB = 3'h5;
	localparam int EIF_CLK_NS = 8;
	localparam int EIF_ANALOG_NS = 60;
	localparam int EIF_AF_CYC = (EIF_ANALOG_NS + EIF_CLK_NS - 1) / EIF_CLK_NS;
	localparam int EIF_ACK_MIN_CLK = 4;
	localparam int EIF_REQ_GAP_CLK = 5;
	typedef struct packed {
		logic en;
		logic two;
		logic [2:0] sel;
	} eif_nf_cfg_t;
	typedef struct packed {
		logic nonsample;
		logic instr_done;
		logic stall;
	} eif_cpu_evt_t;
endpackage

// *** rtl/eif_dnf.sv ***
// digital sampling noise filter for external interrupt input 3
`timescale 1ns/1ps
module eif_dnf (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic din,
	input wire logic subclk_s,
	input wire logic standby,
	input wire eif_pkg::eif_nf_cfg_t cfg,
	output logic dout
);
	import eif_pkg::*;

	logic [9:0] pre;
	logic sub_prev;
	logic [2:0] sel_prev;
	logic [2:0] hist;
	logic [1:0] nsamp;
	logic tick;
	logic agree;

	// sampling clock divider per select code
	function automatic logic [9:0] div_mask(input logic [2:0] sel);
		case (sel)
			3'h0: div_mask = 10'h03F;
			3'h1: div_mask = 10'h07F;
			3'h2: div_mask = 10'h0FF;
			3'h3: div_mask = 10'h1FF;
			default: div_mask = 10'h3FF;
		endcase
	endfunction

	// divided clock stops in standby, so only the subclock can wake
	always_comb begin
		if (cfg.sel == EIF_SEL_SUB) begin
			tick = subclk_s & ~sub_prev;
		end else begin
			tick = !standby && ((pre & div_mask(cfg.sel)) == div_mask(cfg.sel));
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pre <= 10'h000;
			sub_prev <= 1'b0;
		end else begin
			sub_prev <= subclk_s;
			if (!standby) begin
				pre <= pre + 10'h001;
			end
		end
	end

	// three samples, or two when selected, must agree
	assign agree = cfg.two ? (hist[1] == hist[0]) : (hist[2] == hist[1] && hist[1] == hist[0]);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sel_prev <= 3'h0;
			hist <= 3'h0;
			nsamp <= 2'h0;
			dout <= 1'b0;
		end else begin
			sel_prev <= cfg.sel;
			if (sel_prev != cfg.sel) begin
				// history restarts after a clock change
				nsamp <= 2'h0;
			end else if (tick) begin
				hist <= {hist[1:0], din};
				if (nsamp != 2'h3) begin
					nsamp <= nsamp + 2'h1;
				end
			end
			if (agree && nsamp >= (cfg.two ? 2'h2 : 2'h3)) begin
				dout <= hist[0];
			end
		end
	end
endmodule

// *** rtl/eif_top.sv ***
// external interrupt edge detection, noise filtering and CPU request gating
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ps

// Behaviour
// - every maskable pin needs a level held a minimum time before edge.
// - fall and rise bits select none, rising, falling or both edges.
// - first register pair: bit 2 the NMI pin, bits 3-6 inputs 0-3.
// - a separate register pair selects the edge of input 7.
// - a third pair, bits 13-15 of port numbering, controls inputs 4-6.
// - reset clears all edge selects, so nothing is detected.
// - input 3 uses the analog filter, or the digital one when enabled.
// - a 3-bit field picks fxx/64 to fxx/1024 or the subclock.
// - digital filter needs three agreeing samples, or two when selected.
// - pulses under two sampling clocks are rejected with three samples.
// - a stopped sampling clock cannot wake; the subclock one can.
// - filter control sits at FFFFF318H, reset zero, byte access.
// - acknowledge no sooner than 4 clocks; requests spaced 5 clocks (not enforced: requests pass on every detected edge).
// - requests stay pending until the instruction after a non-sample one.
// - the NMI pin is a port pin until enabled by port mode control.
module eif_top (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic nmi_pin,
	input wire logic [7:0] ext_irq_pins,
	input wire logic subclk_pin,
	input wire logic port_mode_nmi,
	input wire logic standby,
	input wire eif_pkg::eif_cpu_evt_t cpu_evt,
	output logic nmi_req,
	output logic [7:0] ext_irq_req,
	output logic cpu_ack_ok
);
	import eif_pkg::*;

	typedef enum logic {
		EIF_OPEN,
		EIF_HELD
	} eif_hold_t;

	localparam logic [3:0] AF_CNT = 4'(EIF_AF_CYC);
	localparam logic [2:0] ACK_CNT = 3'(EIF_ACK_MIN_CLK - 1);
	localparam logic [2:0] GAP_CNT = 3'(EIF_REQ_GAP_CLK);

	logic [7:0] fall0;
	logic [7:0] rise0;
	logic [7:0] fall3;
	logic [7:0] rise3;
	logic [7:0] fall9;
	logic [7:0] rise9;
	logic [7:0] noise_filter_control;
	eif_nf_cfg_t nf_cfg;

	logic wr_pend;
	logic [31:0] wr_addr;
	logic addr_ok;

	logic [8:0] pin_s1;
	logic [8:0] pin_s2;
	logic sub_s1;
	logic sub_s2;
	logic [8:0] filt_af;
	logic [3:0] af_cnt [9];
	logic dnf_out;
	logic [8:0] lvl;
	logic [8:0] lvl_prev;
	logic [8:0] rise_en;
	logic [8:0] fall_en;
	logic [8:0] next_req;

	eif_hold_t hold;
	eif_hold_t next_hold;
	logic [2:0] since_req;

	function automatic logic [7:0] reg_read(input logic [31:0] a);
		case (a)
			EIF_FALL0_ADDR: reg_read = fall0;
			EIF_RISE0_ADDR: reg_read = rise0;
			EIF_FALL3_ADDR: reg_read = fall3;
			EIF_RISE3_ADDR: reg_read = rise3;
			EIF_FALL9_ADDR: reg_read = fall9;
			EIF_RISE9_ADDR: reg_read = rise9;
			EIF_NFC_ADDR: reg_read = noise_filter_control;
			EIF_STAT_ADDR: reg_read = lvl[7:0];
			default: reg_read = 8'h00;
		endcase
	endfunction

	// reserved filter control bits forced low
	function automatic logic [7:0] nfc_mask(input logic [7:0] d);
		nfc_mask = {d[EIF_NF_EN_BIT], d[EIF_NF_CNT_BIT], 3'h0, d[2:0]};
	endfunction

	assign addr_ok = hsel && hready && htrans[1];

	// zero wait state slave, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend <= 1'b0;
			wr_addr <= 32'h0000_0000;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend <= addr_ok && hwrite;
			if (addr_ok) begin
				wr_addr <= haddr;
			end
		end
	end

	// read data set up in address phase; a write to the same word, except the status word, is forwarded
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (addr_ok && !hwrite) begin
			if (wr_pend && wr_addr == haddr && haddr != EIF_STAT_ADDR) begin
				hrdata <= {24'h000000, (haddr == EIF_NFC_ADDR) ? nfc_mask(hwdata[7:0]) : hwdata[7:0]};
			end else begin
				hrdata <= {24'h000000, reg_read(haddr)};
			end
		end
	end

	// whole-byte register writes, all cleared by reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fall0 <= EIF_REG_RST;
			rise0 <= EIF_REG_RST;
			fall3 <= EIF_REG_RST;
			rise3 <= EIF_REG_RST;
			fall9 <= EIF_REG_RST;
			rise9 <= EIF_REG_RST;
			noise_filter_control <= EIF_REG_RST;
		end else if (wr_pend) begin
			case (wr_addr)
				EIF_FALL0_ADDR: fall0 <= hwdata[7:0];
				EIF_RISE0_ADDR: rise0 <= hwdata[7:0];
				EIF_FALL3_ADDR: fall3 <= hwdata[7:0];
				EIF_RISE3_ADDR: rise3 <= hwdata[7:0];
				EIF_FALL9_ADDR: fall9 <= hwdata[7:0];
				EIF_RISE9_ADDR: rise9 <= hwdata[7:0];
				EIF_NFC_ADDR: noise_filter_control <= nfc_mask(hwdata[7:0]);
				default: ;
			endcase
		end
	end

	assign nf_cfg = '{en: noise_filter_control[EIF_NF_EN_BIT], two: noise_filter_control[EIF_NF_CNT_BIT], sel: noise_filter_control[2:0]};

	// index 0 is the NMI pin, index 1+k is external input k
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_s1 <= 9'h000;
			pin_s2 <= 9'h000;
			sub_s1 <= 1'b0;
			sub_s2 <= 1'b0;
		end else begin
			pin_s1 <= {ext_irq_pins, nmi_pin};
			pin_s2 <= pin_s1;
			sub_s1 <= subclk_pin;
			sub_s2 <= sub_s1;
		end
	end

	// persistence filter stands in for the analog delay
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			filt_af <= 9'h000;
			for (int i = 0; i < 9; i++) begin
				af_cnt[i] <= 4'h0;
			end
		end else begin
			for (int i = 0; i < 9; i++) begin
				if (pin_s2[i] == filt_af[i]) begin
					af_cnt[i] <= 4'h0;
				end else if (af_cnt[i] == AF_CNT - 4'h1) begin
					af_cnt[i] <= 4'h0;
					filt_af[i] <= pin_s2[i];
				end else begin
					af_cnt[i] <= af_cnt[i] + 4'h1;
				end
			end
		end
	end

	eif_dnf u_dnf (
		.hclk(hclk),
		.hresetn(hresetn),
		.din(pin_s2[4]),
		.subclk_s(sub_s2),
		.standby(standby),
		.cfg(nf_cfg),
		.dout(dnf_out)
	);

	// input 3 takes the digital filter only while enabled
	always_comb begin
		lvl = filt_af;
		if (nf_cfg.en) begin
			lvl[4] = dnf_out;
		end
	end

	// bit maps: group0 bits 2..6, group3 bit 1, group9 bits 5..7
	assign rise_en = {rise3[EIF_G3_BIT], rise9[EIF_G9_LO +: 3], rise0[EIF_G0_LO +: 4], rise0[EIF_NMI_BIT]};
	assign fall_en = {fall3[EIF_G3_BIT], fall9[EIF_G9_LO +: 3], fall0[EIF_G0_LO +: 4], fall0[EIF_NMI_BIT]};

	// edge pick per the two select bits
	always_comb begin
		next_req = (lvl & ~lvl_prev & rise_en) | (~lvl & lvl_prev & fall_en);
		// pin stays a port pin until port mode hands it over
		next_req[0] = next_req[0] & port_mode_nmi;
	end

	// one-cycle request pulse per valid edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lvl_prev <= 9'h000;
			nmi_req <= 1'b0;
			ext_irq_req <= 8'h00;
		end else begin
			lvl_prev <= lvl;
			nmi_req <= next_req[0];
			ext_irq_req <= next_req[8:1];
		end
	end

	// a new non-sample instruction wins over completion of the prior one
	always_comb begin
		next_hold = hold;
		case (hold)
			EIF_OPEN: begin
				if (cpu_evt.nonsample) begin
					next_hold = EIF_HELD;
				end
			end
			EIF_HELD: begin
				if (cpu_evt.instr_done && !cpu_evt.nonsample) begin
					next_hold = EIF_OPEN;
				end
			end
			default: next_hold = EIF_OPEN;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hold <= EIF_OPEN;
		end else begin
			hold <= next_hold;
		end
	end

	// acknowledge window opens 4 clocks after a request
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			since_req <= GAP_CNT;
			cpu_ack_ok <= 1'b0;
		end else begin
			if (|next_req) begin
				since_req <= 3'h0;
			end else if (since_req != GAP_CNT) begin
				since_req <= since_req + 3'h1;
			end
			cpu_ack_ok <= !(|next_req) && since_req >= ACK_CNT && next_hold == EIF_OPEN && !cpu_evt.stall;
		end
	end

	// checks
	sequence s_req;
		nmi_req || (|ext_irq_req);
	endsequence

	sequence s_quiet4;
		!cpu_ack_ok [*4];
	endsequence

	a_ack_latency_min: assert property (@(posedge hclk) disable iff (!hresetn)
		s_req |-> s_quiet4)
		else $error("acknowledge window opened too soon after a request");

	a_hold_pending_gate: assert property (@(posedge hclk) disable iff (!hresetn)
		cpu_evt.nonsample |=> !cpu_ack_ok ##0 (hold == EIF_HELD))
		else $error("acknowledge allowed right after a non-sample instruction");

	a_nmi_port_gate: assert property (@(posedge hclk) disable iff (!hresetn)
		!$past(port_mode_nmi) |-> !nmi_req)
		else $error("nmi request while pin is a port pin");

	a_nmi_no_edge: assert property (@(posedge hclk) disable iff (!hresetn)
		(fall0[EIF_NMI_BIT] == 1'b0 && rise0[EIF_NMI_BIT] == 1'b0) |=> !nmi_req)
		else $error("nmi request with no edge selected");

	a_req_single_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
		ext_irq_req[0] |=> !ext_irq_req[0])
		else $error("request on input 0 longer than one cycle");

	a_analog_persist: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(filt_af[1]) |-> $past(pin_s2[1], 1) && $past(pin_s2[1], 8))
		else $error("input 0 level passed before persisting");

	a_rise_only_edge: assert property (@(posedge hclk) disable iff (!hresetn)
		($fell(lvl[1]) && !fall_en[1]) |=> !ext_irq_req[0])
		else $error("falling edge on input 0 detected while not selected");

	a_nfc_reserved_zero: assert property (@(posedge hclk) disable iff (!hresetn)
		noise_filter_control[5:3] == 3'h0)
		else $error("reserved filter control bits not zero");

	a_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
		addr_ok |=> hreadyout && !hresp)
		else $error("slave did not answer OKAY at once");
endmodule

// *** tb/eif_pin_model.sv ***
// pin side and cpu side model driving the interrupt front end
`timescale 1ns/1ps
module eif_pin_model (
	input wire logic hclk,
	output logic nmi_pin,
	output logic [7:0] ext_irq_pins,
	output logic subclk_pin,
	output eif_pkg::eif_cpu_evt_t cpu_evt
);
	import eif_pkg::*;
	// unused pins rest low, never toggled
	initial begin
		nmi_pin = 1'b0;
		ext_irq_pins = 8'h00;
		subclk_pin = 1'b0;
		cpu_evt = 3'h0;
	end
	// subclock crystal runs free, unrelated to hclk
	always #61 subclk_pin = ~subclk_pin;
	task automatic flip(input int k);
		@(posedge hclk);
		if (k == 8) nmi_pin <= ~nmi_pin;
		else ext_irq_pins[k] <= ~ext_irq_pins[k];
	endtask
	// k 8 is the nmi pin; level held w cycles
	task automatic pulse(input int k, input int w);
		flip(k);
		repeat (w - 1) @(posedge hclk);
		flip(k);
	endtask
	task automatic evt(input eif_cpu_evt_t e);
		@(posedge hclk);
		cpu_evt <= e;
		@(posedge hclk);
		cpu_evt <= 3'h0;
	endtask
endmodule

// *** tb/eif_bench.sv ***
// self-checking bench of the external interrupt front end
`timescale 1ns/1ps
module ext_irq_edge_detect_filter_bench;
	import eif_pkg::*;
	logic hclk, hresetn, hsel, hwrite, port_mode_nmi, standby, rd_dp, dp;
	logic hreadyout, hresp, nmi_pin, subclk_pin, nmi_req, cpu_ack_ok;
	logic [31:0] haddr, hwdata, hrdata, seed;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [7:0] ext_irq_pins, ext_irq_req;
	eif_cpu_evt_t cpu_evt;
	logic [31:0] rd_q[$];
	logic [8:0] irq_q[$];
	int fails, n_tests, since;
	logic [31:0] regs [7] = '{EIF_FALL0_ADDR, EIF_RISE0_ADDR, EIF_FALL3_ADDR, EIF_RISE3_ADDR,
		EIF_FALL9_ADDR, EIF_RISE9_ADDR, EIF_NFC_ADDR};
	eif_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
		.hrdata, .hreadyout, .hresp, .nmi_pin, .ext_irq_pins, .subclk_pin, .port_mode_nmi, .standby,
		.cpu_evt, .nmi_req, .ext_irq_req, .cpu_ack_ok);
	eif_pin_model pins (.hclk, .nmi_pin, .ext_irq_pins, .subclk_pin, .cpu_evt);
	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end
	task automatic print_verdict();
		if (fails == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_reg(input logic [31:0] e, input logic [31:0] g);
		cmp("register read", e, g);
	endtask
	task automatic chk_req(input logic [8:0] e, input logic [8:0] g);
		cmp("request pulses", 32'(e), 32'(g));
	endtask
	task automatic chk_resp(input logic e, input logic g);
		cmp("bus response", 32'(e), 32'(g));
	endtask
	task automatic chk_ack(input logic e, input logic g);
		cmp("cpu acknowledge gate", 32'(e), 32'(g));
	endtask
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// results are matched in issue order against the notes queued by the driver
	// a data phase only ends at an edge with ready high
	always @(posedge hclk) begin
		if (hreadyout === 1'b1) begin
			if (dp) chk_resp(1'b0, hresp);
			if (rd_dp) chk_reg(rd_q.pop_front(), hrdata);
			dp <= hsel & htrans[1];
			rd_dp <= hsel & htrans[1] & ~hwrite;
		end
		if ({ext_irq_req, nmi_req} !== 9'h000) begin
			since = 0;
			chk_req(irq_q.size() > 0 ? irq_q.pop_front() : 9'h000, {ext_irq_req, nmi_req});
		end else if (since < 9) since++;
		if (since < 5) chk_ack(since == 4, cpu_ack_ok);
	end
	task automatic wait_rdy();
		int i;
		i = 0;
		@(posedge hclk);
		while (hready_low() && i < 20) begin
			@(posedge hclk);
			i++;
		end
		if (i == 20) begin
			cmp("bus ready", 1, 0);
			print_verdict();
		end
	endtask
	function automatic logic hready_low();
		return hreadyout !== 1'b1;
	endfunction
	task automatic bus(input logic [31:0] a, input logic w, input logic [7:0] d, input logic [7:0] e);
		if (!w) rd_q.push_back({24'h000000, e});
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= {24'h000000, d};
		wait_rdy();
	endtask
	task automatic hit(input int k, input int w, input logic r, input logic f, input int s);
		logic [8:0] oh;
		oh = (k == 8) ? 9'h001 : 9'h002 << k;
		if (r) irq_q.push_back(oh);
		if (f) irq_q.push_back(oh);
		pins.pulse(k, w);
		repeat (s) @(posedge hclk);
		cmp("missing requests", 0, irq_q.size());
		irq_q.delete();
	endtask
	task automatic modes(input int k, input int b, input logic [31:0] fa, input logic [31:0] ra);
		for (int m = 0; m < 4; m++) begin
			bus(fa, 1'b1, 8'(m[1]) << b, 8'h00);
			bus(ra, 1'b1, 8'(m[0]) << b, 8'h00);
			hit(k, 20, m[0], m[1], 40);
		end
		hit(k, 3, 1'b0, 1'b0, 30);
		bus(fa, 1'b1, 8'h00, 8'h00);
		bus(ra, 1'b1, 8'h00, 8'h00);
	endtask
	initial begin
		logic [7:0] d;
		int div;
		since = 9;
		fails = 0;
		n_tests = 0;
		seed = 32'd82538;
		rd_dp = 1'b0;
		dp = 1'b0;
		{hresetn, hsel, hwrite, port_mode_nmi, standby} = 5'h00;
		{haddr, hwdata, htrans, hsize} = '0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		foreach (regs[i]) bus(regs[i], 1'b0, 8'h00, 8'h00);
		foreach (regs[i]) begin
			d = 8'(xs()) & (i == 6 ? 8'hFD : 8'hFF);
			bus(regs[i], 1'b1, d, 8'h00);
			bus(regs[i], 1'b0, 8'h00, i == 6 ? d & 8'hC7 : d);
			bus(regs[i], 1'b1, 8'h00, 8'h00);
		end
		bus(32'hFFFFF31C, 1'b1, 8'hFF, 8'h00);
		bus(32'hFFFFF31C, 1'b0, 8'h00, 8'h00);
		bus(EIF_STAT_ADDR, 1'b1, 8'hFF, 8'h00);
		bus(EIF_STAT_ADDR, 1'b0, 8'h00, 8'h00);
		bus(EIF_RISE0_ADDR, 1'b1, 8'h04, 8'h00);
		hit(8, 20, 1'b0, 1'b0, 40);
		port_mode_nmi <= 1'b1;
		modes(8, EIF_NMI_BIT, EIF_FALL0_ADDR, EIF_RISE0_ADDR);
		modes(0, EIF_G0_LO, EIF_FALL0_ADDR, EIF_RISE0_ADDR);
		modes(3, EIF_G0_LO + 3, EIF_FALL0_ADDR, EIF_RISE0_ADDR);
		modes(7, EIF_G3_BIT, EIF_FALL3_ADDR, EIF_RISE3_ADDR);
		modes(4, EIF_G9_LO, EIF_FALL9_ADDR, EIF_RISE9_ADDR);
		modes(6, EIF_G9_LO + 2, EIF_FALL9_ADDR, EIF_RISE9_ADDR);
		bus(EIF_RISE0_ADDR, 1'b1, 8'h40, 8'h00);
		bus(EIF_FALL0_ADDR, 1'b1, 8'h40, 8'h00);
		for (int c = 0; c < 6; c++) begin
			div = (c == 5) ? 16 : 64 << c;
			bus(EIF_NFC_ADDR, 1'b1, {1'b1, c[0], 3'h0, c[2:0]}, 8'h00);
			repeat (4 * div) @(posedge hclk);
			hit(3, div - 1, 1'b0, 1'b0, 4 * div);
			hit(3, 5 * div, 1'b1, 1'b1, 5 * div);
			// exactly two samples fit this width on a fixed divider
			if (c < 5) hit(3, 2 * div, c[0], c[0], 5 * div);
		end
		bus(EIF_NFC_ADDR, 1'b1, 8'h80, 8'h00);
		repeat (256) @(posedge hclk);
		standby <= 1'b1;
		hit(3, 400, 1'b0, 1'b0, 400);
		standby <= 1'b0;
		pins.evt(3'h4);
		@(posedge hclk);
		chk_ack(1'b0, cpu_ack_ok);
		pins.evt(3'h2);
		repeat (3) @(posedge hclk);
		chk_ack(1'b1, cpu_ack_ok);
		pins.evt(3'h1);
		@(posedge hclk);
		chk_ack(1'b0, cpu_ack_ok);
		// a reset in mid-run must clear every register again
		foreach (regs[i]) bus(regs[i], 1'b1, 8'h81, 8'h00);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		foreach (regs[i]) bus(regs[i], 1'b0, 8'h00, 8'h00);
		print_verdict();
	end
	initial begin
		#1000000;
		cmp("run time limit", 0, 1);
		print_verdict();
	end
endmodule
